// ===== pkg/pmc_consts.svh
// Purpose: Constants for the counter-array channel 1 and 2 mode control.
// Assumes: Register addresses are special-function register addresses.
// Notes:   Included by its bare name.
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

`define PMC_CH1_MODE_ADDR 8'hDB
`define PMC_CH2_MODE_ADDR 8'hDC
`define PMC_CH1_CCL_ADDR  8'hE9
`define PMC_CH1_CCH_ADDR  8'hEA
`define PMC_CH2_CCL_ADDR  8'hEB
`define PMC_CH2_CCH_ADDR  8'hEC

`define PMC_BIT_WIDE      7
`define PMC_BIT_COMP      6
`define PMC_BIT_RISE      5
`define PMC_BIT_FALL      4
`define PMC_BIT_MATCH     3
`define PMC_BIT_TOGGLE    2
`define PMC_BIT_PWM       1
`define PMC_BIT_IRQ_MASK  0

`define PMC_MODE_RESET    8'h00
`define PMC_CCR_RESET     16'h0000
`define PMC_RDATA_UNMAP   8'h00

`endif

// ===== pkg/pmc_pkg.sv
// Purpose: Types shared by the channel mode control files.
// Assumes: Nothing beyond the constants header.
// Notes:   Wave modes are decoded from the mode register bits.
package pmc_pkg;
  typedef logic [7:0]  pmc_byte_t;
  typedef logic [15:0] pmc_word_t;
  typedef enum logic [2:0] {
    PMC_IDLE,
    PMC_TOGGLE,
    PMC_PWM8,
    PMC_WIDE_MODULATION_SELECT,
    PMC_FREQ
  } pmc_wave_t;
endpackage

// ===== rtl/pmc_wave.sv
// Purpose: Output waveform generator for one counter-array channel.
// Assumes: Match strobes come from the control block, one per counter step.
// Notes:   Pin output and enable are both registered.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_wave (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire pmc_pkg::pmc_byte_t mode,
  input  wire pmc_pkg::pmc_word_t ccr,
  input  wire pmc_pkg::pmc_word_t cnt,
  input  wire logic          match_evt,
  input  wire logic          low_match_evt,
  output logic               pin_out,
  output logic               pin_oe_n
);
  import pmc_pkg::*;

  pmc_wave_t wave_mode;
  logic      pin_r;
  logic      pin_nxt;
  logic      oe_n_r;
  wire       comp_on   = mode[`PMC_BIT_COMP];
  wire       tog_on    = mode[`PMC_BIT_TOGGLE];
  wire       pwm_on    = mode[`PMC_BIT_PWM];
  wire       drive_nxt = tog_on | pwm_on;

  // Toggle together with pulse-width selects frequency output, never plain toggle.
  always_comb begin
    if (!comp_on) begin
      wave_mode = PMC_IDLE;
    end else if (tog_on && pwm_on) begin
      wave_mode = PMC_FREQ;
    end else if (pwm_on) begin
      wave_mode = mode[`PMC_BIT_WIDE] ? PMC_WIDE_MODULATION_SELECT : PMC_PWM8;
    end else if (tog_on) begin
      wave_mode = PMC_TOGGLE;
    end else begin
      wave_mode = PMC_IDLE;
    end
  end

  // The 8 or 16-bit width choice is made above from the width bit; this block runs both cases.
  always_comb begin
    case (wave_mode)
      PMC_TOGGLE: pin_nxt = match_evt ? ~pin_r : pin_r;
      PMC_FREQ:   pin_nxt = low_match_evt ? ~pin_r : pin_r;
      PMC_PWM8:   pin_nxt = cnt[7:0] < ccr[7:0];
      PMC_WIDE_MODULATION_SELECT:  pin_nxt = cnt < ccr;
      default:    pin_nxt = pin_r;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_r  <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      pin_r  <= pin_nxt;
      oe_n_r <= ~drive_nxt;
    end
  end

  assign pin_out  = pin_r;
  assign pin_oe_n = oe_n_r;
endmodule
`default_nettype wire

// ===== rtl/pmc_mode_ctrl.sv
// Purpose: Mode registers, capture, match flags and pins of channels 1 and 2.
// Assumes: The counter value and register port are synchronous to sys_clk.
// Notes:   Read data appears one cycle after the read strobe.
// How it works
// - Pulse-width mode gives 16-bit modulation if width bit set, else 8-bit.
// - Comparator match flag and pin level work only while bit 6 of mode is set; pin enable needs only bit 2 or 1.
// - Bit 5 set makes the channel capture on a rising input edge.
// - Bit 4 set makes the channel capture on a falling input edge.
// - With bit 3 set, counter equal to compare value sets the channel flag.
// - With bit 2 set, a compare match inverts the channel output pin.
// - Toggle and pulse-width bits together select frequency output mode.
// - With bit 1 set and bit 2 clear, the pin carries a pulse-width modulated waveform.
// - Bit 0 gates the flag onto the channel interrupt request.
// - Low byte write clears comparator enable; high byte write sets it.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_mode_ctrl (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic [7:0]         sfr_addr,
  input  wire logic               sfr_wr,
  input  wire logic               sfr_rd,
  input  wire pmc_pkg::pmc_byte_t sfr_wdata,
  output logic [7:0]              sfr_rdata,
  input  wire pmc_pkg::pmc_word_t counter_value,
  input  wire logic               channel1_flag_clear,
  input  wire logic               channel2_flag_clear,
  output logic                    channel1_event_flag,
  output logic                    channel2_event_flag,
  output logic                    channel1_irq,
  output logic                    channel2_irq,
  input  wire logic               channel1_pin_in,
  output logic                    channel1_pin_out,
  output logic                    channel1_pin_oe_n,
  input  wire logic               channel2_pin_in,
  output logic                    channel2_pin_out,
  output logic                    channel2_pin_oe_n
);
  import pmc_pkg::*;

  pmc_byte_t mode_r [2];
  pmc_word_t ccr_r [2];
  logic      flag_r [2];
  logic      irq_r [2];
  logic      pin_in_prev_r [2];
  pmc_word_t cnt_prev_r;
  pmc_byte_t rdata_r;
  logic      pin_in [2];
  logic      flag_clear [2];
  logic      pin_out [2];
  logic      pin_oe_n [2];
  logic      wr_mode [2];
  logic      wr_low [2];
  logic      wr_high [2];
  logic      cap_evt [2];
  logic      match_evt [2];
  logic      low_match_evt [2];

  // Matches fire only when the counter moves, so a parked counter fires once.
  wire cnt_moved = counter_value != cnt_prev_r;

  assign pin_in[0]     = channel1_pin_in;
  assign pin_in[1]     = channel2_pin_in;
  assign flag_clear[0] = channel1_flag_clear;
  assign flag_clear[1] = channel2_flag_clear;

  assign wr_mode[0] = sfr_wr && (sfr_addr == `PMC_CH1_MODE_ADDR);
  assign wr_mode[1] = sfr_wr && (sfr_addr == `PMC_CH2_MODE_ADDR);
  assign wr_low[0]  = sfr_wr && (sfr_addr == `PMC_CH1_CCL_ADDR);
  assign wr_low[1]  = sfr_wr && (sfr_addr == `PMC_CH2_CCL_ADDR);
  assign wr_high[0] = sfr_wr && (sfr_addr == `PMC_CH1_CCH_ADDR);
  assign wr_high[1] = sfr_wr && (sfr_addr == `PMC_CH2_CCH_ADDR);

  wire pmc_byte_t rd_mux =
    (sfr_addr == `PMC_CH1_MODE_ADDR) ? mode_r[0] :
    (sfr_addr == `PMC_CH2_MODE_ADDR) ? mode_r[1] :
    (sfr_addr == `PMC_CH1_CCL_ADDR)  ? ccr_r[0][7:0] :
    (sfr_addr == `PMC_CH1_CCH_ADDR)  ? ccr_r[0][15:8] :
    (sfr_addr == `PMC_CH2_CCL_ADDR)  ? ccr_r[1][7:0] :
    (sfr_addr == `PMC_CH2_CCH_ADDR)  ? ccr_r[1][15:8] :
    `PMC_RDATA_UNMAP;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_r    <= `PMC_RDATA_UNMAP;
      cnt_prev_r <= `PMC_CCR_RESET;
    end else begin
      rdata_r    <= sfr_rd ? rd_mux : rdata_r;
      cnt_prev_r <= counter_value;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire rise = pin_in[ch] & ~pin_in_prev_r[ch];
      wire fall = ~pin_in[ch] & pin_in_prev_r[ch];
      assign cap_evt[ch] = (rise && mode_r[ch][`PMC_BIT_RISE]) ||
                           (fall && mode_r[ch][`PMC_BIT_FALL]);
      assign match_evt[ch] = cnt_moved && (counter_value == ccr_r[ch]);
      assign low_match_evt[ch] = cnt_moved && (counter_value[7:0] == ccr_r[ch][7:0]);
      wire flag_set = cap_evt[ch] ||
                      (match_evt[ch] && mode_r[ch][`PMC_BIT_MATCH] &&
                       mode_r[ch][`PMC_BIT_COMP]);
      pmc_byte_t mode_nxt;
      pmc_word_t ccr_nxt;

      // Low byte write drops the comparator, high byte write re-arms it.
      always_comb begin
        mode_nxt = mode_r[ch];
        if (wr_mode[ch]) begin
          mode_nxt = sfr_wdata;
        end else if (wr_low[ch]) begin
          mode_nxt[`PMC_BIT_COMP] = 1'b0;
        end else if (wr_high[ch]) begin
          mode_nxt[`PMC_BIT_COMP] = 1'b1;
        end
      end

      // A capture edge beats a software write landing in the same cycle.
      always_comb begin
        ccr_nxt = ccr_r[ch];
        if (cap_evt[ch]) begin
          ccr_nxt = counter_value;
        end else if (wr_low[ch]) begin
          ccr_nxt[7:0] = sfr_wdata;
        end else if (wr_high[ch]) begin
          ccr_nxt[15:8] = sfr_wdata;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          mode_r[ch]        <= `PMC_MODE_RESET;
          ccr_r[ch]         <= `PMC_CCR_RESET;
          flag_r[ch]        <= 1'b0;
          irq_r[ch]         <= 1'b0;
          pin_in_prev_r[ch] <= 1'b0;
        end else begin
          mode_r[ch]        <= mode_nxt;
          ccr_r[ch]         <= ccr_nxt;
          flag_r[ch]        <= flag_set | (flag_r[ch] & ~flag_clear[ch]);
          irq_r[ch]         <= flag_r[ch] & mode_r[ch][`PMC_BIT_IRQ_MASK];
          pin_in_prev_r[ch] <= pin_in[ch];
        end
      end

      pmc_wave u_wave (
        .sys_clk       (sys_clk),
        .reset_n       (reset_n),
        .mode          (mode_r[ch]),
        .ccr           (ccr_r[ch]),
        .cnt           (counter_value),
        .match_evt     (match_evt[ch]),
        .low_match_evt (low_match_evt[ch]),
        .pin_out       (pin_out[ch]),
        .pin_oe_n      (pin_oe_n[ch])
      );

      wire comp  = mode_r[ch][`PMC_BIT_COMP];
      wire toggle_enable   = mode_r[ch][`PMC_BIT_TOGGLE];
      wire pwm   = mode_r[ch][`PMC_BIT_PWM];
      wire wide  = mode_r[ch][`PMC_BIT_WIDE];

      sequence s_mode_write;
        wr_mode[ch] ##1 (sfr_rd && !sfr_wr &&
                         sfr_addr == (ch == 0 ? `PMC_CH1_MODE_ADDR : `PMC_CH2_MODE_ADDR));
      endsequence

      mode_readback_a: assert property (s_mode_write |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("Mode register did not read back as written.");
      comp_clear_a: assert property (wr_low[ch] |=> !mode_r[ch][`PMC_BIT_COMP])
        else $error("Low byte write left comparator enabled.");
      comp_set_a: assert property (wr_high[ch] |=> mode_r[ch][`PMC_BIT_COMP])
        else $error("High byte write did not enable comparator.");
      capture_copy_a: assert property (cap_evt[ch] |=>
                                       ccr_r[ch] == $past(counter_value) && flag_r[ch])
        else $error("Capture did not copy the counter and set the flag.");
      rise_capture_a: assert property ((mode_r[ch][`PMC_BIT_RISE] && $rose(pin_in[ch]))
                                       |-> cap_evt[ch])
        else $error("Rising edge was not captured.");
      fall_capture_a: assert property ((mode_r[ch][`PMC_BIT_FALL] && $fell(pin_in[ch]))
                                       |-> cap_evt[ch])
        else $error("Falling edge was not captured.");
      match_flag_a: assert property ((match_evt[ch] && comp && mode_r[ch][`PMC_BIT_MATCH])
                                     |=> flag_r[ch])
        else $error("Match did not set the channel flag.");
      toggle_pin_a: assert property ((comp && toggle_enable && !pwm && match_evt[ch])
                                     |=> pin_out[ch] != $past(pin_out[ch]))
        else $error("Match did not toggle the pin.");
      comp_off_a: assert property (!comp |=> $stable(pin_out[ch]))
        else $error("Pin moved with comparator disabled.");
      freq_mode_a: assert property ((comp && toggle_enable && pwm && !low_match_evt[ch])
                                    |=> $stable(pin_out[ch]))
        else $error("Frequency mode pin moved without a low byte match.");
      pwm_wide_a: assert property ((comp && pwm && !toggle_enable && wide)
                                   |=> pin_out[ch] ==
                                       ($past(counter_value) < $past(ccr_r[ch])))
        else $error("16-bit modulation level is wrong.");
      pwm_narrow_a: assert property ((comp && pwm && !toggle_enable && !wide)
                                     |=> pin_out[ch] ==
                                         ($past(counter_value[7:0]) < $past(ccr_r[ch][7:0])))
        else $error("8-bit modulation level is wrong.");
      irq_mask_a: assert property (!mode_r[ch][`PMC_BIT_IRQ_MASK] |=> !irq_r[ch])
        else $error("Masked flag raised an interrupt.");
      irq_follow_a: assert property ((flag_r[ch] && mode_r[ch][`PMC_BIT_IRQ_MASK])
                                     |=> irq_r[ch])
        else $error("Unmasked flag did not raise an interrupt.");
    end
  endgenerate

  assign sfr_rdata           = rdata_r;
  assign channel1_event_flag = flag_r[0];
  assign channel2_event_flag = flag_r[1];
  assign channel1_irq        = irq_r[0];
  assign channel2_irq        = irq_r[1];
  assign channel1_pin_out    = pin_out[0];
  assign channel2_pin_out    = pin_out[1];
  assign channel1_pin_oe_n   = pin_oe_n[0];
  assign channel2_pin_oe_n   = pin_oe_n[1];
endmodule
`default_nettype wire

// ===== bench/pmc_pin_model.sv
// Purpose: External pin model for one counter-array channel.
// Assumes: The bench sets the source level just after a clock edge.
// Notes:   SLOW adds one cycle of source delay, as a sluggish driver would.
`timescale 1ns/10ps
`default_nettype none
module pmc_pin_model #(
  parameter bit SLOW = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic ext_lvl,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_in
);
  logic ext_r;
  always_ff @(posedge sys_clk) begin
    ext_r <= ext_lvl;
  end
  // While the channel drives, the wire follows the channel and not the source.
  assign pin_in = pin_oe_n ? (SLOW ? ext_r : ext_lvl) : pin_out;
endmodule
`default_nettype wire

// ===== bench/tb_pmc_mode_ctrl.sv
// Purpose: Self-checking bench for the channel 1 and 2 mode control.
// Assumes: Read data and status are compared one edge after they are taken.
// Notes:   Status byte is oe2, pin2, oe1, pin1, irq2, irq1, flag2, flag1.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"
module tb_pmc_mode_ctrl;
  import pmc_pkg::*;
  typedef struct packed {logic sel; pmc_byte_t mask; pmc_byte_t exp;} pmc_note_t;
  logic      sys_clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, chk = 1'b0;
  logic      clr1 = 1'b0, clr2 = 1'b0, ext1 = 1'b0, ext2 = 1'b0, pend_r = 1'b0, psel_r = 1'b0;
  logic      f1, f2, q1, q2, pi1, pi2, po1, po2, oe1, oe2;
  logic [7:0] sfr_addr = 8'h00, sfr_rdata, lfsr_r = 8'h35, d;
  pmc_byte_t sfr_wdata = 8'h00;
  pmc_word_t cnt = 16'h0000, cmp;
  int        error_cnt = 0, num_checks = 0;
  pmc_note_t notes[$];
  pmc_note_t nt;

  always #2 sys_clk = ~sys_clk;

  pmc_mode_ctrl pmc_mode_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .counter_value(cnt), .channel1_flag_clear(clr1), .channel2_flag_clear(clr2),
    .channel1_event_flag(f1), .channel2_event_flag(f2), .channel1_irq(q1), .channel2_irq(q2),
    .channel1_pin_in(pi1), .channel1_pin_out(po1), .channel1_pin_oe_n(oe1),
    .channel2_pin_in(pi2), .channel2_pin_out(po2), .channel2_pin_oe_n(oe2));
  pmc_pin_model #(.SLOW(1'b0)) pin1_model (.sys_clk(sys_clk), .ext_lvl(ext1), .pin_out(po1),
    .pin_oe_n(oe1), .pin_in(pi1));
  pmc_pin_model #(.SLOW(1'b1)) pin2_model (.sys_clk(sys_clk), .ext_lvl(ext2), .pin_out(po2),
    .pin_oe_n(oe2), .pin_in(pi2));

  function automatic pmc_byte_t rnd();
    lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    return lfsr_r;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk) #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = v;
    @(posedge sys_clk) #1;
    sfr_wr = 1'b0;
  endtask
  // Write and read back on consecutive edges, the tightest order the bus allows.
  task automatic wrd(input logic [7:0] a, input logic [7:0] v);
    notes.push_back('{1'b0, 8'hFF, v});
    @(posedge sys_clk) #1;
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = v;
    @(posedge sys_clk) #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    @(posedge sys_clk) #1;
    sfr_rd = 1'b0;
  endtask
  task automatic note(input logic sel, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    notes.push_back('{sel, m, e});
    @(posedge sys_clk) #1;
    chk = sel;
    sfr_rd = ~sel;
    sfr_addr = a;
    @(posedge sys_clk) #1;
    chk = 1'b0;
    sfr_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    note(1'b0, a, 8'hFF, e);
  endtask
  task automatic pr(input logic [7:0] m, input logic [7:0] e);
    note(1'b1, 8'h00, m, e);
  endtask
  task automatic stp(input pmc_word_t c);
    cnt = c;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic clr();
    @(posedge sys_clk) #1;
    clr1 = 1'b1;
    clr2 = 1'b1;
    @(posedge sys_clk) #1;
    clr1 = 1'b0;
    clr2 = 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Results land one edge after the request, so the oldest note always matches.
  always @(posedge sys_clk) begin
    if (pend_r) begin
      nt = notes.pop_front();
      check((psel_r ? {oe2, po2, oe1, po1, q2, q1, f2, f1} : sfr_rdata) & nt.mask, nt.exp);
    end
    pend_r <= sfr_rd | chk;
    psel_r <= chk;
  end

  initial begin
    #20000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    rd(`PMC_CH1_MODE_ADDR, 8'h00);
    rd(`PMC_CH2_MODE_ADDR, 8'h00);
    pr(8'hFF, 8'hA0);
    wr(8'hDD, 8'hFF);
    rd(8'hDD, 8'h00);
    // All-ones last: counter and compare are both zero, so no pin can move yet.
    for (int i = 0; i < 6; i++) begin
      d = (i > 3) ? 8'hFF : rnd();
      if (i > 1) begin
        wrd(i[0] ? `PMC_CH2_MODE_ADDR : `PMC_CH1_MODE_ADDR, d);
      end else begin
        wr(i[0] ? `PMC_CH2_MODE_ADDR : `PMC_CH1_MODE_ADDR, d);
        rd(i[0] ? `PMC_CH2_MODE_ADDR : `PMC_CH1_MODE_ADDR, d);
      end
    end
    wr(`PMC_CH1_MODE_ADDR, 8'h00);
    wr(`PMC_CH2_MODE_ADDR, 8'h00);
    pr(8'hFF, 8'hA0);
    wr(`PMC_CH1_CCH_ADDR, 8'h00);
    rd(`PMC_CH1_MODE_ADDR, 8'h40);
    wr(`PMC_CH1_CCL_ADDR, 8'h00);
    rd(`PMC_CH1_MODE_ADDR, 8'h00);
    $display("test registers done");
    cmp = {rnd(), rnd()};
    cnt = cmp;
    wr(`PMC_CH1_MODE_ADDR, 8'h10);
    ext1 = 1'b1;
    stp(cmp);
    pr(8'h05, 8'h00);
    wr(`PMC_CH1_MODE_ADDR, 8'h21);
    ext1 = 1'b0;
    stp(cmp);
    pr(8'h05, 8'h00);
    ext1 = 1'b1;
    stp(cmp);
    pr(8'h05, 8'h05);
    rd(`PMC_CH1_CCL_ADDR, cmp[7:0]);
    rd(`PMC_CH1_CCH_ADDR, cmp[15:8]);
    cmp = {rnd(), rnd()};
    cnt = cmp;
    wr(`PMC_CH2_MODE_ADDR, 8'h11);
    ext2 = 1'b1;
    stp(cmp);
    ext2 = 1'b0;
    stp(cmp);
    pr(8'h0A, 8'h0A);
    rd(`PMC_CH2_CCL_ADDR, cmp[7:0]);
    rd(`PMC_CH2_CCH_ADDR, cmp[15:8]);
    wr(`PMC_CH2_CCH_ADDR, 8'h00);
    rd(`PMC_CH2_MODE_ADDR, 8'h51);
    wr(`PMC_CH2_CCL_ADDR, 8'h00);
    rd(`PMC_CH2_MODE_ADDR, 8'h11);
    clr();
    pr(8'h0F, 8'h00);
    $display("test capture done");
    cmp = {rnd(), rnd()};
    wr(`PMC_CH1_CCL_ADDR, cmp[7:0]);
    wr(`PMC_CH1_CCH_ADDR, cmp[15:8]);
    wr(`PMC_CH1_MODE_ADDR, 8'h08);
    stp(cmp - 16'h0001);
    stp(cmp);
    pr(8'h05, 8'h00);
    wr(`PMC_CH1_MODE_ADDR, 8'h48);
    stp(cmp - 16'h0001);
    stp(cmp);
    pr(8'h05, 8'h01);
    clr();
    wr(`PMC_CH1_MODE_ADDR, 8'h44);
    for (int i = 0; i < 2; i++) begin
      stp(cmp - 16'h0001);
      stp(cmp);
      pr(8'h30, i[0] ? 8'h00 : 8'h10);
    end
    stp(cmp ^ 16'h0101);
    stp(cmp ^ 16'h0100);
    pr(8'h30, 8'h00);
    wr(`PMC_CH1_MODE_ADDR, 8'h46);
    stp(cmp ^ 16'h0101);
    stp(cmp ^ 16'h0100);
    pr(8'h30, 8'h10);
    wr(`PMC_CH1_CCL_ADDR, 8'h80);
    wr(`PMC_CH1_CCH_ADDR, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(`PMC_CH1_MODE_ADDR, i[1] ? 8'hC2 : 8'h42);
      stp(i[0] ? 16'h20F0 : 16'h9010);
      pr(8'h30, (i[1] ? (cnt < 16'h4080) : (cnt[7:0] < 8'h80)) ? 8'h10 : 8'h00);
    end
    $display("test waveform done");
    conclude();
  end
endmodule
`default_nettype wire
